// File: logic/rbsg_map.svh
// rbsg_map.svh: offsets, field positions, reset values and timing counts
// for the bus decode and RAM gate block.
// assumes: included by its bare name from the package and the design modules.
`ifndef RBSG_MAP_SVH
`define RBSG_MAP_SVH

// address space split
`define RBSG_ADDR_W        17
`define RBSG_INT_LAST      17'h0003F
`define RBSG_LOC_COUNT     64
`define RBSG_CLK_COUNT     14
`define RBSG_USER_COUNT    50

// clock register indices
`define RBSG_CMD_IDX       4'hB

// command register fields and reset value
`define RBSG_CMD_TE_BIT    7
`define RBSG_CMD_RO_MASK   8'h03
`define RBSG_CMD_RESET     8'h80

// power-up write protection hold-off
`define RBSG_CLK_HZ        40000000
`define RBSG_HOLD_MS       150
`define RBSG_HOLD_CYCLES   ((`RBSG_HOLD_MS * (`RBSG_CLK_HZ / 1000)))

`endif

// File: logic/rbsg_pkg.sv
// rbsg_pkg.sv: types shared by the bus decode and RAM gate block.
// assumes: nothing beyond the constants header.
`include "rbsg_map.svh"

package rbsg_pkg;

	// host bus cycle state, gray coded idle -> read -> write
	typedef enum logic [1:0]
	{
		RBSG_IDLE  = 2'b00,
		RBSG_READ  = 2'b01,
		RBSG_WRITE = 2'b11
	} rbsg_cycle_t;

	// one byte of register or user storage
	typedef logic [7:0] rbsg_byte_t;

endpackage

// File: logic/rbsg_user_ram.sv
// rbsg_user_ram.sv: general purpose on-chip byte storage.
// assumes: one write port, one read port, read data registered.
`timescale 1ns/1ps
`include "rbsg_map.svh"

module rbsg_user_ram
	import rbsg_pkg::*;
#(
	parameter int DEPTH = `RBSG_USER_COUNT,
	parameter int AW    = 6
)
(
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          reset,
	// write side
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire rbsg_byte_t    wr_data,
	// read side
	input  wire logic [AW-1:0] rd_addr,
	output rbsg_byte_t         rd_data
);

	rbsg_byte_t mem [DEPTH];   // storage cells, no reset on purpose
	rbsg_byte_t next_rd_data;  // read value before its register

	////////////////////////////////////////////////////////////////////
	// read lookup, out of range indices read as zero
	always_comb
	begin
		next_rd_data = 8'h00;
		if (int'(rd_addr) < DEPTH)
		begin
			next_rd_data = mem[rd_addr];
		end
	end

	// storage write, no reset so it maps onto plain RAM cells
	always_ff @(posedge core_clk)
	begin
		if (wr_en && (int'(wr_addr) < DEPTH))
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read data register
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			rd_data <= 8'h00;
		end
		else
		begin
			rd_data <= next_rd_data;
		end
	end

endmodule

// File: logic/rbsg_supply_guard.sv
// rbsg_supply_guard.sv: write protection while supply is bad and for a
// hold-off after it returns.
// assumes: fail level is already synchronous to core_clk.
`timescale 1ns/1ps
`include "rbsg_map.svh"

module rbsg_supply_guard
	import rbsg_pkg::*;
#(
	parameter int HOLD_CYCLES = `RBSG_HOLD_CYCLES,
	parameter int CW          = $clog2(HOLD_CYCLES + 1)
)
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// supply status
	input  wire logic below_threshold,
	output logic      protect
);

	logic [CW-1:0] hold_cnt;       // remaining hold-off cycles
	logic [CW-1:0] next_hold_cnt;  // next count
	logic          next_protect;   // next protection level

	////////////////////////////////////////////////////////////////////
	// reload while the supply is bad, count down once it is good
	always_comb
	begin
		next_hold_cnt = hold_cnt;
		if (below_threshold)
		begin
			next_hold_cnt = CW'(HOLD_CYCLES);
		end
		else if (hold_cnt != '0)
		begin
			next_hold_cnt = hold_cnt - CW'(1);
		end
		next_protect = below_threshold || (next_hold_cnt != '0);
	end

	// reset is treated as a power-up: protection starts with a full hold
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			hold_cnt <= CW'(HOLD_CYCLES);
			protect  <= 1'b1;
		end
		else
		begin
			hold_cnt <= next_hold_cnt;
			protect  <= next_protect;
		end
	end

endmodule

// File: logic/rbsg_bus_gate.sv
// rbsg_bus_gate.sv: host bus front end: address decode, strobe framing,
// clock register file, user bytes and external RAM gating.
// assumes: host strobes and address are synchronous to core_clk and held
// stable during each cycle; time counting logic supplies the internal copy.
//
// Behaviour
// R1 - seventeen bit byte address, one space
// R2 - clock registers at lowest fourteen addresses
// R3 - sixty four internal bytes overlay low RAM
// R4 - read when write high, select and enable low
// R5 - internal read drives addressed byte out
// R6 - RAM output gate idle on internal read
// R7 - external read forwards host output enable
// R8 - write spans later fall to earlier rise
// R9 - host holds address through write
// R10 - host keeps output enable high writing
// R11 - falling write enable turns drivers off
// R12 - internal write stores the byte
// R13 - external write goes to RAM only
// R14 - bad supply gates off host select
// R15 - supply fail output active until good
// R16 - bad supply holds RAM select high
// R17 - 150 ms hold-off after supply returns
// R18 - fourteen eight bit internal registers
// R19 - host copy refreshed by simultaneous transfer
// R20 - time, date, alarm registers hold BCD
// R21 - register B is command register
// R22 - locations 0E..3F are free user bytes
// R23 - good supply passes select to RAM
// R24 - internal byte captured at write rise
// R25 - data drivers off except internal read
`timescale 1ns/1ps
`include "rbsg_map.svh"

module rbsg_bus_gate
	import rbsg_pkg::*;
#(
	parameter int HOLD_CYCLES = `RBSG_HOLD_CYCLES,
	parameter int NREG        = `RBSG_CLK_COUNT
)
(
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    reset,
	// host bus
	input  wire logic [`RBSG_ADDR_W-1:0] host_address_bus,
	input  wire logic                    chip_sel_n,
	input  wire logic                    out_en_n,
	input  wire logic                    wr_en_n,
	input  wire rbsg_byte_t              data_in,
	output rbsg_byte_t                   data_out,
	output logic                         data_oe,
	// external RAM control
	output logic                         ram_select_out_n,
	output logic                         ram_output_gate_out_n,
	// supply monitor
	input  wire logic                    supply_fail_threshold,
	output logic                         supply_fail_out_n,
	// time keeping side
	input  wire logic                    transfer_pulse,
	input  wire logic [NREG*8-1:0]       internal_copy,
	output logic                         transfer_enable
);

	////////////////////////////////////////////////////////////////////
	// declarations

	logic        protect;          // write protection from supply guard
	logic        sel_ok;           // host select after supply gating
	logic        addr_internal;    // address falls in the on-chip window
	logic        read_req;         // read framing this cycle
	logic        write_req;        // write framing this cycle

	rbsg_cycle_t cycle;            // current bus cycle state
	rbsg_cycle_t next_cycle;       // next bus cycle state
	logic [5:0]  wr_idx;           // latched write location
	logic [5:0]  next_wr_idx;      // next latched location
	rbsg_byte_t  wr_byte;          // latched write data
	rbsg_byte_t  next_wr_byte;     // next latched data
	logic        wr_internal;      // latched write targets on-chip byte
	logic        next_wr_internal; // next latched target
	logic        commit;           // write cycle ended this cycle

	rbsg_byte_t  clk_regs [NREG];  // host copy of clock registers
	rbsg_byte_t  next_clk_regs [NREG];

	logic        ram_we;           // user byte write strobe
	logic [5:0]  ram_waddr;        // user byte write index
	logic [5:0]  ram_raddr;        // user byte read index
	rbsg_byte_t  ram_rdata;        // registered user byte
	logic        rd_from_ram;      // read index hits user bytes
	logic        rd_from_ram_q;    // aligned with ram_rdata
	rbsg_byte_t  reg_rdata_q;      // registered clock register byte

	rbsg_byte_t  next_data_out;    // output flop inputs
	logic        next_data_oe;
	logic        next_ram_sel_n;
	logic        next_ram_gate_n;
	logic        next_fail_n;

	////////////////////////////////////////////////////////////////////
	// supply guard and its hold-off counter

	rbsg_supply_guard
	#(
		.HOLD_CYCLES (HOLD_CYCLES)
	)
	u_guard
	(
		.core_clk        (core_clk),
		.reset           (reset),
		.below_threshold (supply_fail_threshold),
		.protect         (protect)
	);

	////////////////////////////////////////////////////////////////////
	// address decode and strobe framing

	// select is gated internally while protection is on
	always_comb
	begin
		sel_ok        = !chip_sel_n && !protect;                         // [R14]
		addr_internal = (host_address_bus <= `RBSG_INT_LAST);            // [R1] [R3]
		read_req      = sel_ok && !out_en_n && wr_en_n;                  // [R4]
		write_req     = sel_ok && !wr_en_n;                              // [R8]
	end

	////////////////////////////////////////////////////////////////////
	// bus cycle state and write latch

	// a write lasts while select and write enable are both low; the
	// sample of the last low cycle is what gets stored at the rise
	always_comb
	begin
		next_cycle       = RBSG_IDLE;
		next_wr_idx      = wr_idx;
		next_wr_byte     = wr_byte;
		next_wr_internal = wr_internal;
		commit           = 1'b0;
		case (cycle)
			RBSG_IDLE,
			RBSG_READ:
			begin
				if (write_req)
				begin
					next_cycle = RBSG_WRITE;
				end
				else if (read_req)
				begin
					next_cycle = RBSG_READ;
				end
			end
			RBSG_WRITE:
			begin
				// earlier rising edge of select or write enable ends it
				if (write_req)
				begin
					next_cycle = RBSG_WRITE;
				end
				else
				begin
					commit = 1'b1;                                       // [R24]
				end
			end
			default:
			begin
				next_cycle = RBSG_IDLE;
			end
		endcase
		// address is held by the host, so sampling each write cycle is safe
		if (write_req)
		begin
			next_wr_idx      = host_address_bus[5:0];                    // [R9]
			next_wr_byte     = data_in;
			next_wr_internal = addr_internal;                            // [R13]
		end
	end

	// bus cycle registers
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			cycle       <= RBSG_IDLE;
			wr_idx      <= 6'h00;
			wr_byte     <= 8'h00;
			wr_internal <= 1'b0;
		end
		else
		begin
			cycle       <= next_cycle;
			wr_idx      <= next_wr_idx;
			wr_byte     <= next_wr_byte;
			wr_internal <= next_wr_internal;
		end
	end

	////////////////////////////////////////////////////////////////////
	// clock register file

	// host write wins over a transfer in the same cycle for that byte;
	// command register flag bits are read-only to the host
	always_comb
	begin
		// enable taken first so the transfer gate never sees a stale copy
		transfer_enable = clk_regs[`RBSG_CMD_IDX][`RBSG_CMD_TE_BIT];
		for (int i = 0; i < NREG; i++)
		begin
			next_clk_regs[i] = clk_regs[i];
			if (transfer_pulse && transfer_enable && (i != int'(`RBSG_CMD_IDX)))
			begin
				next_clk_regs[i] = internal_copy[i*8 +: 8];              // [R19] [R20]
			end
		end
		if (commit && wr_internal && (int'(wr_idx) < NREG))
		begin
			if (wr_idx[3:0] == `RBSG_CMD_IDX)
			begin
				next_clk_regs[`RBSG_CMD_IDX] = (wr_byte & ~`RBSG_CMD_RO_MASK)
					| (clk_regs[`RBSG_CMD_IDX] & `RBSG_CMD_RO_MASK);    // [R21]
			end
			else
			begin
				next_clk_regs[wr_idx[3:0]] = wr_byte;                    // [R12] [R18]
			end
		end
	end

	// clock register flops, command register starts with updates on
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < NREG; i++)
			begin
				clk_regs[i] <= (i == int'(`RBSG_CMD_IDX)) ? `RBSG_CMD_RESET : 8'h00;
			end
		end
		else
		begin
			for (int i = 0; i < NREG; i++)
			begin
				clk_regs[i] <= next_clk_regs[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// user bytes above the clock registers

	always_comb
	begin
		ram_we      = commit && wr_internal && (int'(wr_idx) >= NREG);   // [R22]
		ram_waddr   = wr_idx - 6'(NREG);                                 // [R2]
		rd_from_ram = (int'(host_address_bus[5:0]) >= NREG);
		ram_raddr   = host_address_bus[5:0] - 6'(NREG);
	end

	rbsg_user_ram
	#(
		.DEPTH (`RBSG_LOC_COUNT - NREG),
		.AW    (6)
	)
	u_user_ram
	(
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (ram_we),
		.wr_addr  (ram_waddr),
		.wr_data  (wr_byte),
		.rd_addr  (ram_raddr),
		.rd_data  (ram_rdata)
	);

	// read path stage aligned with the registered user byte
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			rd_from_ram_q <= 1'b0;
			reg_rdata_q   <= 8'h00;
		end
		else
		begin
			rd_from_ram_q <= rd_from_ram;
			reg_rdata_q   <= (int'(host_address_bus[5:0]) < NREG)
				? clk_regs[host_address_bus[3:0]] : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin outputs, all from flops

	// data drivers only for an internal read; a low write enable drops
	// them because read_req needs write enable high
	always_comb
	begin
		next_data_out   = rd_from_ram_q ? ram_rdata : reg_rdata_q;      // [R5]
		next_data_oe    = read_req && addr_internal;                    // [R11] [R25]
		// select passes straight through while protection is off
		next_ram_sel_n  = protect ? 1'b1 : chip_sel_n;                  // [R16] [R23]
		// internal reads keep the RAM quiet, external ones pass enable on
		next_ram_gate_n = (sel_ok && !addr_internal) ? out_en_n : 1'b1; // [R6] [R7]
		next_fail_n     = !protect;                                     // [R15] [R17]
	end

	// output registers, RAM idle and supply fail active during reset
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			data_out              <= 8'h00;
			data_oe               <= 1'b0;
			ram_select_out_n      <= 1'b1;
			ram_output_gate_out_n <= 1'b1;
			supply_fail_out_n     <= 1'b0;
		end
		else
		begin
			data_out              <= next_data_out;
			data_oe               <= next_data_oe;
			ram_select_out_n      <= next_ram_sel_n;
			ram_output_gate_out_n <= next_ram_gate_n;
			supply_fail_out_n     <= next_fail_n;
		end
	end

endmodule

// File: test/rbsg_bus_gate_properties.sv
// rbsg_bus_gate_properties.sv: port timing checks for the bus gate.
// assumes: bound to rbsg_bus_gate, single clock domain.
`timescale 1ns/1ps

module rbsg_gate_checker
	import rbsg_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        reset,
	// host bus
	input wire logic [16:0] host_address_bus,
	input wire logic        chip_sel_n,
	input wire logic        out_en_n,
	input wire logic        wr_en_n,
	input wire logic        data_oe,
	// ram gate and supply
	input wire logic        ram_select_out_n,
	input wire logic        ram_output_gate_out_n,
	input wire logic        supply_fail_threshold,
	input wire logic        supply_fail_out_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	logic prev_thr; // threshold one edge ago
	logic good;     // no protection in flight
	logic rd_req;   // host read strobes
	logic low_adr;  // internal 64 byte window
	assign good    = supply_fail_out_n & ~supply_fail_threshold & ~prev_thr;
	assign rd_req  = ~chip_sel_n & ~out_en_n & wr_en_n;
	assign low_adr = host_address_bus <= 17'h0003F;

	// reset counts as bad supply, so good starts false
	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			prev_thr <= 1'b1;
		else
			prev_thr <= supply_fail_threshold;

	a_drive_only_read: assert property (data_oe |-> $past(rd_req && low_adr))
		else $error("data driven outside internal read");
	a_read_drives_bus: assert property (good && rd_req && low_adr |=> data_oe)
		else $error("internal read not driven");
	a_gate_only_ext: assert property (!ram_output_gate_out_n |-> $past(!low_adr))
		else $error("ram output gate on internal address");
	a_ext_read_forward: assert property (good && rd_req && !low_adr
		|=> !ram_output_gate_out_n && !data_oe) else $error("external read not forwarded");
	a_select_pass: assert property (good |=> ram_select_out_n == $past(chip_sel_n))
		else $error("select not passed to ram");
	a_fail_blocks_ram: assert property (supply_fail_threshold |-> ##3 ram_select_out_n)
		else $error("ram selected on bad supply");
	a_fail_out_low: assert property (supply_fail_threshold |-> ##3 !supply_fail_out_n)
		else $error("fail output not active");
	a_fail_no_drive: assert property (!supply_fail_out_n && !$past(supply_fail_out_n)
		|-> !data_oe) else $error("bus driven while protected");
	a_we_kills_oe: assert property (data_oe && !wr_en_n |=> !data_oe)
		else $error("drivers kept on after write enable");
	a_hold_off_low: assert property ($fell(supply_fail_threshold)
		|=> (!supply_fail_out_n) [*8]) else $error("hold-off too short");
endmodule

bind rbsg_bus_gate rbsg_gate_checker chk (.core_clk, .reset, .host_address_bus,
	.chip_sel_n, .out_en_n, .wr_en_n, .data_oe, .ram_select_out_n,
	.ram_output_gate_out_n, .supply_fail_threshold, .supply_fail_out_n);

// File: test/rbsg_host_model.sv
// rbsg_host_model.sv: host processor on the bytewide strobe bus.
// assumes: outputs change on falling edges of core_clk.
`timescale 1ns/1ps

module rbsg_host_model
	import rbsg_pkg::*;
(
	// clock and read side
	input wire logic       core_clk,
	input wire rbsg_byte_t data_out,
	input wire logic       data_oe,
	input wire logic       ram_output_gate_out_n,
	// host strobes
	output logic [16:0]    address,
	output logic           cs_n,
	output logic           oe_n,
	output logic           we_n,
	output rbsg_byte_t     data
);
	initial
	begin
		address = 17'h00000;
		data = 8'h00;
		idle();
	end

	// strobes off; data toggled so a stale byte never looks held
	task automatic idle();
		cs_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		data = ~data;
	endtask

	// one write cycle, output enable high, address kept past the rise
	task automatic wr(input logic [16:0] a, input rbsg_byte_t d);
		@(negedge core_clk);
		address = a;
		data = d;
		oe_n = 1'b1;
		cs_n = 1'b0;
		we_n = 1'b0;
		@(negedge core_clk);
		idle();
		@(negedge core_clk);
	endtask

	// read; kill drops write enable mid-read, rewriting the same byte
	task automatic rd(input logic [16:0] a, input bit kill, output rbsg_byte_t d,
		output logic oe, output logic gate, output logic oe_after);
		@(negedge core_clk);
		address = a;
		cs_n = 1'b0;
		oe_n = 1'b0;
		we_n = 1'b1;
		repeat (3) @(negedge core_clk);
		d = data_out;
		oe = data_oe;
		gate = ram_output_gate_out_n;
		oe_after = 1'b0;
		if (kill)
		begin
			data = d;
			we_n = 1'b0;
			@(negedge core_clk);
			oe_after = data_oe;
		end
		idle();
		@(negedge core_clk);
	endtask
endmodule

// File: test/rbsg_bus_gate_bench.sv
// rbsg_bus_gate_bench.sv: self-checking bench for the bus gate.
// assumes: short hold-off parameter, host model drives the bus.
`timescale 1ns/1ps

module rbsg_bus_gate_bench;
	import rbsg_pkg::*;
	localparam int HOLD = 20; // shortened hold-off
	logic         core_clk;
	logic         reset;
	logic         thr;
	logic         tpulse;
	logic [111:0] copy;
	logic [16:0]  adr;
	logic         cs_n, oe_n, we_n, oe, gate, ko, te, sel_n, fail_n, gate_n;
	logic         oe_seen; // driver enable as the host model saw it
	rbsg_byte_t   din, dout, d;
	int           mismatches, comparisons, n;

	rbsg_bus_gate #(.HOLD_CYCLES(HOLD)) dut (.core_clk(core_clk), .reset(reset),
		.host_address_bus(adr), .chip_sel_n(cs_n), .out_en_n(oe_n), .wr_en_n(we_n),
		.data_in(din), .data_out(dout), .data_oe(oe), .ram_select_out_n(sel_n),
		.ram_output_gate_out_n(gate_n), .supply_fail_threshold(thr),
		.supply_fail_out_n(fail_n), .transfer_pulse(tpulse), .internal_copy(copy),
		.transfer_enable(te));
	rbsg_host_model host (.core_clk(core_clk), .data_out(dout), .data_oe(oe),
		.ram_output_gate_out_n(gate_n), .address(adr), .cs_n(cs_n), .oe_n(oe_n),
		.we_n(we_n), .data(din));

	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// internal read: byte, driver on, ram gate idle
	task automatic rd_chk(input logic [16:0] a, input rbsg_byte_t exp);
		host.rd(a, 1'b0, d, oe_seen, gate, ko);
		check("read data", d, exp);
		check("data_oe", {7'h00, oe_seen}, 8'h01);
		check("ram gate", {7'h00, gate}, 8'h01);
	endtask

	// bounded wait for the fail output to clear
	task automatic wait_good();
		n = 0;
		while (fail_n !== 1'b1 && n < 200)
		begin
			@(negedge core_clk);
			n++;
		end
	endtask

	task automatic pulse();
		@(negedge core_clk);
		tpulse = 1'b1;
		@(negedge core_clk);
		tpulse = 1'b0;
	endtask

	task automatic finish_test();
		if (mismatches == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// watchdog: whole run is a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		finish_test();
	end

	initial
	begin
		reset = 1'b1;
		thr = 1'b0;
		tpulse = 1'b0;
		for (int i = 0; i < 14; i++)
			copy[i*8+:8] = 8'h40 + 8'(i);
		repeat (6) @(negedge core_clk);
		reset = 1'b0;
		wait_good();
		for (int i = 0; i < 14; i++)
			if (i != 11)
				host.wr(17'(i), 8'h20 + 8'(i));
		host.wr(17'h0000E, 8'h5A);
		host.wr(17'h0003F, 8'hC3);
		for (int i = 0; i < 14; i++)
			if (i != 11)
				rd_chk(17'(i), 8'h20 + 8'(i));
		rd_chk(17'h0000E, 8'h5A);
		rd_chk(17'h0003F, 8'hC3);
		// transfer frozen, then enabled
		host.wr(17'h0000B, 8'h03);
		check("te", {7'h00, te}, 8'h00);
		rd_chk(17'h0000B, 8'h00);
		pulse();
		rd_chk(17'h00000, 8'h20);
		host.wr(17'h0000B, 8'h80);
		pulse();
		rd_chk(17'h00000, 8'h40);
		rd_chk(17'h0000B, 8'h80);
		// external writes must not alias onto internal bytes
		host.wr(17'h00040, 8'hA5);
		host.wr(17'h1003F, 8'h00);
		rd_chk(17'h00000, 8'h40);
		rd_chk(17'h0003F, 8'hC3);
		host.rd(17'h00100, 1'b0, d, oe_seen, gate, ko);
		check("ext oe", {7'h00, oe_seen}, 8'h00);
		check("ext gate", {7'h00, gate}, 8'h00);
		host.rd(17'h0003F, 1'b1, d, oe_seen, gate, ko);
		check("oe after we", {7'h00, ko}, 8'h00);
		rd_chk(17'h0003F, 8'hC3);
		// supply failure, refused write, hold-off
		thr = 1'b1;
		repeat (4) @(negedge core_clk);
		check("fail out", {7'h00, fail_n}, 8'h00);
		check("ram select", {7'h00, sel_n}, 8'h01);
		host.wr(17'h0000E, 8'hEE);
		thr = 1'b0;
		wait_good();
		check("hold-off", {7'h00, n >= HOLD && n <= HOLD + 4}, 8'h01);
		rd_chk(17'h0000E, 8'h5A);
		finish_test();
	end
endmodule
